// File: squib_diag_regs.svh
/*
 Constants for the squib diagnostic sequencer and its response words.
 Assumes inclusion by the response module only.
*/
// How it works
// - High-resistance compare result latched at next diag select fall after settle.
// - A FET diagnostic command first clears all FET result flags.
// - Bias off or leakage at FET start: MOS stays off, abort, fault flag set.
// - Fire permit active on channel under test: refuse FET test, set fault flag.
// - No leakage and no fire permit: turn on selected high or low MOS.
// - Current above short threshold: switch driver off within shutoff time.
// - No threshold crossing: timeout flag high during timeout, MOS off at expiry.
// - FET results latched at select fall, held until next diagnostic write.
// - A response bit shows FET test completion; it reads 0 while a test runs.
// - Safing check drives test current on selected input, reports 00, 01 or 11.
// - Reserve voltage check reports 00, 01 or 11, captured at select fall.
// - Safing current only on selected reserve input; result captured at select fall.
// - Lost ground blocks only that channel's low driver; all else works.
// - Lost ground shows only in the low-side MOS diagnostic; the code uses GROUND_OK in no diagnostic.
// - Words are 16 bits with D13 set for odd parity; commands checked.
// - Response to a command goes out in the next valid select frame.
// - After reset, ground loss or reference fault first response is zero.
// - Parity or message error in deployment 0xD000; bad bit count 0xD003.
// - Fire without arm 0xD005; message not allowed in deployment 0xD009.
// - Soft reset: key 0xAA answers 1X02 with limit bits, then 0x55 answers 0x2003.
// - Fire permit per channel is external input OR internal latch.
`ifndef SQUIB_DIAG_REGS_SVH
`define SQUIB_DIAG_REGS_SVH
`define CLK_MHZ 200
`define SHUTOFF_NS 10000
`define SHUTOFF_CYC ((`SHUTOFF_NS * `CLK_MHZ) / 1000)
`define FET_TIMEOUT_NS 2000000
`define FET_TIMEOUT_CYC ((`FET_TIMEOUT_NS * `CLK_MHZ) / 1000)
`define HR_SETTLE_NS 100000
`define HR_SETTLE_CYC ((`HR_SETTLE_NS * `CLK_MHZ) / 1000 + 1)
`define RSP_ZERO 16'h0000
`define RSP_PAR_ERR 16'hD000
`define RSP_LEN_ERR 16'hD003
`define RSP_SEQ_ERR 16'hD005
`define RSP_DEP_ERR 16'hD009
`define RSP_SR_DONE 16'h2003
`define RSP_SR_KEY1 8'h02
`define KEY_FIRST 8'hAA
`define KEY_SECOND 8'h55
`define PAR_BIT 13
`define DONE_BIT 7
`endif

// File: squib_diag_pkg.sv
/*
 Types for the squib diagnostic sequencer.
 Assumes the constants header is compiled with it.
*/
package squib_diag_pkg;
   typedef enum logic [1:0] {FET_IDLE = 2'b00, FET_ON = 2'b01, FET_WAIT = 2'b11} fet_state_type;
   typedef enum logic [1:0] {GRP_CFG = 2'b00, GRP_DEP = 2'b01, GRP_DIAG = 2'b10,
      GRP_MON = 2'b11} group_type;
   typedef enum logic [2:0] {DG_OFF = 3'd0, DG_LEAK = 3'd1, DG_VRES = 3'd2, DG_SAFE = 3'd3,
      DG_RES = 3'd4, DG_HIRES = 3'd5, DG_LS = 3'd6, DG_HS = 3'd7} diag_type;
endpackage : squib_diag_pkg

// File: squib_diag_spi_response.sv
/*
 Squib diagnostic sequencer and response word builder for the first SPI port.
 Assumes an external shifter hands over each 16-bit command with a bit count,
 pulses at the diagnostic select fall, and comparator levels synchronous to SYS_CLK.
*/
`timescale 1ns/1ps
`include "squib_diag_regs.svh"
module squib_diag_spi_response
   import squib_diag_pkg::*;
#(
   parameter int CHANNELS = 8,
   parameter int SHUTOFF_CYCLES = `SHUTOFF_CYC,
   parameter int TIMEOUT_CYCLES = `FET_TIMEOUT_CYC,
   parameter int SETTLE_CYCLES = `HR_SETTLE_CYC
)
(
   input wire logic SYS_CLK,
   input wire logic NRST,
   input wire logic FRAME_DONE,
   input wire logic [15:0] CMD_WORD,
   input wire logic [4:0] CMD_BITS,
   input wire logic CS_FALL,
   input wire logic GROUND_LOST,
   input wire logic REF_FAULT,
   input wire logic DEPLOYING,
   input wire logic ARMED,
   input wire logic BIAS_ON,
   input wire logic LEAK_SEEN,
   input wire logic BATTERY_SHORT_CMP,
   input wire logic GROUND_SHORT_CMP,
   input wire logic HIGH_RES_CMP,
   input wire logic [1:0] SAFE_CMP,
   input wire logic [1:0] RESERVE_CMP,
   input wire logic [CHANNELS-1:0] FIRE_PERMIT_PIN,
   input wire logic [CHANNELS-1:0] FIRE_PERMIT_LATCH,
   input wire logic [CHANNELS-1:0] GROUND_OK,
   input wire logic [CHANNELS-1:0] LOW_FIRE_REQ,
   input wire logic [1:0] CURRENT_LIMIT_BITS,
   output logic [15:0] RSP_WORD,
   output logic [CHANNELS-1:0] HS_MOS_ON,
   output logic [CHANNELS-1:0] LS_MOS_ON,
   output logic [CHANNELS-1:0] LS_FIRE_EN,
   output logic [CHANNELS-1:0] SAFING_TEST_CURRENT,
   output logic SOFT_RESET
);
   localparam int CW = $clog2(CHANNELS);
   localparam int TW = $clog2(TIMEOUT_CYCLES + SETTLE_CYCLES + 1);

   fet_state_type fet_reg, fet_next;
   diag_type diag_reg;
   logic [CW-1:0] chan_reg;
   logic [TW-1:0] cnt_reg, cnt_next;
   logic fault_present_flag, fet_timeout_flag, battery_short_flag, ground_short_flag;
   logic fet_done_reg, high_res_reg, key_reg, first_reg, held_reg, live_reg;
   logic [1:0] code_reg;
   logic [15:0] pend_reg, rsp_next;
   logic [CHANNELS-1:0] fire_permit;

   function automatic logic [15:0] with_parity(input logic [15:0] w);
      logic [15:0] r;
      r = w;
      r[`PAR_BIT] = 1'b0;
      r[`PAR_BIT] = ~(^r);
      return r;
   endfunction : with_parity

   function automatic logic [1:0] thermo(input logic [1:0] c);
      return {c[1], c[1] | c[0]};
   endfunction : thermo

   // Command decode
   wire parity_ok = ^CMD_WORD;
   wire len_ok = (CMD_BITS == 5'd16);
   group_type grp;
   assign grp = group_type'(CMD_WORD[15:14]);
   wire diag_cmd = (grp == GRP_DIAG);
   wire fire_cmd = (grp == GRP_DEP) && (CMD_WORD[12:8] == 5'b00000);
   wire [CW-1:0] cmd_chan = CMD_WORD[CW-1:0];
   diag_type cmd_diag;
   assign cmd_diag = diag_type'(CMD_WORD[10:8]);
   wire fet_cmd = diag_cmd && (cmd_diag == DG_LS || cmd_diag == DG_HS);
   wire cfg_reset = (grp == GRP_CFG) && !CMD_WORD[10];
   wire key1 = cfg_reset && CMD_WORD[7:0] == `KEY_FIRST;
   wire key2 = cfg_reset && key_reg && CMD_WORD[7:0] == `KEY_SECOND;
   wire running = (fet_reg != FET_IDLE);
   wire start_fet = FRAME_DONE && len_ok && parity_ok && fet_cmd && !running;
   wire new_diag = FRAME_DONE && len_ok && parity_ok && diag_cmd && !running;

   assign fire_permit = FIRE_PERMIT_PIN | FIRE_PERMIT_LATCH;
   wire chan_permit = fire_permit[cmd_chan];
   wire pre_ok = BIAS_ON && !LEAK_SEEN && !chan_permit;
   wire hit = (diag_reg == DG_HS) ? BATTERY_SHORT_CMP : GROUND_SHORT_CMP;
   // A test launched this cycle drives its MOS from the command, not the stale selection
   diag_type sel_diag;
   assign sel_diag = start_fet ? cmd_diag : diag_reg;
   wire [CW-1:0] sel_chan = start_fet ? cmd_chan : chan_reg;

   // FET test sequencer
   always_comb
   begin
      fet_next = fet_reg;
      cnt_next = cnt_reg;
      case (fet_reg)
         FET_IDLE:
         begin
            if (start_fet && pre_ok)
            begin
               fet_next = FET_ON;
               cnt_next = '0;
            end
         end
         FET_ON:
         begin
            cnt_next = cnt_reg + 1'b1;
            if (hit)
               fet_next = FET_IDLE;
            else if (cnt_reg == TW'(TIMEOUT_CYCLES - 1))
               fet_next = FET_IDLE;
         end
         default: fet_next = FET_IDLE;
      endcase
   end

   always_ff @(posedge SYS_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         fet_reg <= FET_IDLE;
         cnt_reg <= '0;
      end
      else
      begin
         fet_reg <= fet_next;
         cnt_reg <= new_diag && !fet_cmd ? '0 : (running || start_fet ? cnt_next :
            (cnt_reg == TW'(SETTLE_CYCLES) ? cnt_reg : cnt_reg + 1'b1));
      end
   end

   // Diagnostic selection and flags
   always_ff @(posedge SYS_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         diag_reg <= DG_OFF;
         chan_reg <= '0;
         fault_present_flag <= 1'b0;
         fet_timeout_flag <= 1'b0;
         battery_short_flag <= 1'b0;
         ground_short_flag <= 1'b0;
         fet_done_reg <= 1'b0;
         high_res_reg <= 1'b0;
         code_reg <= 2'b00;
         held_reg <= 1'b0;
      end
      else
      begin
         if (new_diag)
         begin
            diag_reg <= cmd_diag;
            chan_reg <= cmd_chan;
            high_res_reg <= 1'b0;
            code_reg <= 2'b00;
            held_reg <= 1'b0;
            battery_short_flag <= 1'b0;
            ground_short_flag <= 1'b0;
            fet_timeout_flag <= 1'b0;
            fault_present_flag <= fet_cmd && !pre_ok;
            fet_done_reg <= fet_cmd && !pre_ok;
         end
         else
         begin
            if (fet_reg == FET_ON)
               fet_timeout_flag <= !hit && cnt_reg != TW'(TIMEOUT_CYCLES - 1);
            if (fet_reg == FET_ON && fet_next == FET_IDLE)
               fet_done_reg <= 1'b1;
            // Only the first select fall after a diagnostic command captures; later frames reread it
            if (CS_FALL && !held_reg && (diag_reg == DG_HS || diag_reg == DG_LS))
            begin
               held_reg <= 1'b1;
               battery_short_flag <= BATTERY_SHORT_CMP;
               ground_short_flag <= GROUND_SHORT_CMP;
            end
            if (CS_FALL && diag_reg == DG_HIRES && cnt_reg == TW'(SETTLE_CYCLES))
               high_res_reg <= HIGH_RES_CMP;
            if (CS_FALL && diag_reg == DG_SAFE)
               code_reg <= thermo(SAFE_CMP);
            if (CS_FALL && diag_reg == DG_VRES)
               code_reg <= thermo(RESERVE_CMP);
         end
      end
   end

   // Response selection, sent in the following frame
   wire [15:0] diag_rsp = {2'b10, 1'b0, 1'b0, 1'b0, diag_reg, fet_done_reg, high_res_reg,
      code_reg, fault_present_flag, fet_timeout_flag, battery_short_flag, ground_short_flag};
   wire [15:0] key1_rsp = {4'h1, 2'b10, CURRENT_LIMIT_BITS, `RSP_SR_KEY1};
   wire [15:0] cmd_rsp = !len_ok ? `RSP_LEN_ERR :
      (!parity_ok && DEPLOYING) ? `RSP_PAR_ERR :
      (fire_cmd && !ARMED) ? `RSP_SEQ_ERR :
      (DEPLOYING && grp == GRP_DIAG) ? `RSP_DEP_ERR :
      key2 ? `RSP_SR_DONE : key1 ? key1_rsp : with_parity(diag_rsp);
   wire wipe = GROUND_LOST || REF_FAULT || first_reg;

   always_comb
   begin
      rsp_next = RSP_WORD;
      if (CS_FALL)
         rsp_next = wipe ? `RSP_ZERO : pend_reg;
      // Status answers are rebuilt a cycle later so they carry what this fall latched
      else if (live_reg)
         rsp_next = with_parity(diag_rsp);
   end

   always_ff @(posedge SYS_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         pend_reg <= `RSP_ZERO;
         RSP_WORD <= `RSP_ZERO;
         first_reg <= 1'b1;
         key_reg <= 1'b0;
         SOFT_RESET <= 1'b0;
         live_reg <= 1'b0;
      end
      else
      begin
         RSP_WORD <= rsp_next;
         if (CS_FALL)
            first_reg <= GROUND_LOST || REF_FAULT;
         live_reg <= CS_FALL && !wipe && pend_reg[15:14] == 2'b10;
         if (FRAME_DONE)
            pend_reg <= cmd_rsp;
         else if (CS_FALL)
            pend_reg <= with_parity(diag_rsp);
         if (FRAME_DONE)
            key_reg <= key1 && len_ok && parity_ok;
         SOFT_RESET <= FRAME_DONE && key2 && len_ok && parity_ok;
      end
   end

   // Drivers: lost ground only blocks that channel's low side
   genvar g;
   generate
      for (g = 0; g < CHANNELS; g++)
      begin : drv
         always_ff @(posedge SYS_CLK or negedge NRST)
         begin
            if (!NRST)
            begin
               HS_MOS_ON[g] <= 1'b0;
               LS_MOS_ON[g] <= 1'b0;
               LS_FIRE_EN[g] <= 1'b0;
               SAFING_TEST_CURRENT[g] <= 1'b0;
            end
            else
            begin
               HS_MOS_ON[g] <= fet_next == FET_ON && sel_diag == DG_HS &&
                  sel_chan == CW'(g);
               LS_MOS_ON[g] <= fet_next == FET_ON && sel_diag == DG_LS &&
                  sel_chan == CW'(g);
               LS_FIRE_EN[g] <= LOW_FIRE_REQ[g] && GROUND_OK[g];
               SAFING_TEST_CURRENT[g] <= diag_reg == DG_SAFE && chan_reg == CW'(g);
            end
         end
      end
   endgenerate
endmodule : squib_diag_spi_response

// File: squib_host_model.sv
/*
 Host model on the first SPI port: opens frames and hands over commands.
 Assumes a free-running clock shared with the block.
*/
`timescale 1ns/1ps
module squib_host_model
(
   input wire logic clk,
   output logic frame_done,
   output logic [15:0] cmd_word,
   output logic [4:0] cmd_bits,
   output logic cs_fall
);
   initial {frame_done, cs_fall, cmd_word, cmd_bits} = '0;
   // Select fall opens the frame; the word lands as it closes
   task automatic xfer(input logic [15:0] w, input logic [4:0] n, input logic good);
      logic [15:0] t;
      t = {w[15:14], 1'b0, w[12:0]};
      t[13] = ~^t ^ ~good; // Odd parity unless a bad word is wanted
      @(negedge clk) cs_fall = 1'b1;
      @(negedge clk) cs_fall = 1'b0;
      repeat (3) @(negedge clk);
      {frame_done, cmd_word, cmd_bits} = {1'b1, t, n};
      @(negedge clk) frame_done = 1'b0;
      // Released lines show the inverse, so a stale 16-bit word fails the length check
      {cmd_word, cmd_bits} = ~{t, n};
   endtask : xfer
endmodule : squib_host_model

// File: squib_diag_spi_response_chk.sv
/*
 Checker for the squib response block, bound to its ports.
 Assumes select pulses and frames are spaced several cycles apart.
*/
`timescale 1ns/1ps
module squib_diag_spi_response_chk
#(
   parameter int CHANNELS = 8,
   parameter int SHUTOFF_CYCLES = 20,
   parameter int TIMEOUT_CYCLES = 50
)
(
   input wire logic SYS_CLK,
   input wire logic NRST,
   input wire logic FRAME_DONE,
   input wire logic [4:0] CMD_BITS,
   input wire logic CS_FALL,
   input wire logic GROUND_LOST,
   input wire logic REF_FAULT,
   input wire logic BIAS_ON,
   input wire logic LEAK_SEEN,
   input wire logic BATTERY_SHORT_CMP,
   input wire logic GROUND_SHORT_CMP,
   input wire logic [CHANNELS-1:0] FIRE_PERMIT_PIN,
   input wire logic [CHANNELS-1:0] FIRE_PERMIT_LATCH,
   input wire logic [CHANNELS-1:0] GROUND_OK,
   input wire logic [15:0] RSP_WORD,
   input wire logic [CHANNELS-1:0] HS_MOS_ON,
   input wire logic [CHANNELS-1:0] LS_MOS_ON,
   input wire logic [CHANNELS-1:0] LS_FIRE_EN,
   input wire logic [CHANNELS-1:0] SAFING_TEST_CURRENT
);
   logic len_bad_reg;
   logic [19:0] on_cnt_reg;
   wire logic [CHANNELS-1:0] permit = FIRE_PERMIT_PIN | FIRE_PERMIT_LATCH;
   wire logic mos_any = |(HS_MOS_ON | LS_MOS_ON);
   always_ff @(posedge SYS_CLK or negedge NRST)
      if (!NRST)
         len_bad_reg <= 1'b0;
      else if (FRAME_DONE)
         len_bad_reg <= CMD_BITS != 5'd16;
   // Counts how long any driver stays on, to bound the test timeout
   always_ff @(posedge SYS_CLK or negedge NRST)
      if (!NRST)
         on_cnt_reg <= '0;
      else
         on_cnt_reg <= mos_any ? on_cnt_reg + 20'd1 : '0;
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!NRST);
   sequence s_len_answer;
      CS_FALL && len_bad_reg && !GROUND_LOST && !REF_FAULT;
   endsequence
   a_len_error: assert property (s_len_answer |=> ##1 RSP_WORD == 16'hD003)
      else $error("length error answer missing");
   a_rsp_parity: assert property ($changed(RSP_WORD) && |RSP_WORD[15:13] |-> ^RSP_WORD)
      else $error("response parity even");
   a_rsp_on_cs: assert property (
      $changed(RSP_WORD) |-> $past(CS_FALL) || $past(CS_FALL, 2))
      else $error("response changed outside frame start");
   a_hs_off: assert property (
      |HS_MOS_ON && BATTERY_SHORT_CMP |-> ##[1:SHUTOFF_CYCLES] !HS_MOS_ON)
      else $error("high driver not shut off");
   a_ls_off: assert property (
      |LS_MOS_ON && GROUND_SHORT_CMP |-> ##[1:SHUTOFF_CYCLES] !LS_MOS_ON)
      else $error("low driver not shut off");
   a_fet_tmo: assert property (on_cnt_reg <= TIMEOUT_CYCLES + 1)
      else $error("driver on past timeout");
   a_start_ok: assert property (
      $rose(mos_any) |-> $past(BIAS_ON) && !$past(LEAK_SEEN) &&
      !($past(permit) & (HS_MOS_ON | LS_MOS_ON)))
      else $error("driver started against a precondition");
   a_ls_ground: assert property (|LS_FIRE_EN |-> !(LS_FIRE_EN & ~$past(GROUND_OK)))
      else $error("low fire enable without ground");
   a_safe_one: assert property ($onehot0(SAFING_TEST_CURRENT))
      else $error("safing current on several inputs");
   a_code_legal: assert property (
      $changed(RSP_WORD) && RSP_WORD[15:14] == 2'b10 |-> RSP_WORD[5:4] != 2'b10)
      else $error("two-bit code shows 10");
endmodule : squib_diag_spi_response_chk
bind squib_diag_spi_response squib_diag_spi_response_chk #(.CHANNELS(CHANNELS),
   .SHUTOFF_CYCLES(SHUTOFF_CYCLES), .TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_chk (.*);

// File: squib_diag_spi_response_tb_top.sv
/*
 Self-checking bench for the squib diagnostic response block.
 Assumes the host model and checker are compiled before it.
*/
`timescale 1ns/1ps
module squib_diag_spi_response_tb_top
   import squib_diag_pkg::*;
   ;
   localparam int SHUT = 20;
   localparam int TMO = 50;
   localparam int SETTLE = 20;
   localparam logic [15:0] MON = 16'hC000;
   logic sys_clk, nrst, frame_done, cs_fall, ground_lost, ref_fault, deploying, armed, bias_on;
   logic leak_seen, bat_cmp, gnd_cmp, hr_cmp, soft_reset, sr_seen;
   logic [15:0] cmd_word, rsp_word, ew;
   logic [4:0] cmd_bits;
   logic [1:0] safe_cmp, res_cmp, cl_bits, c;
   logic [7:0] permit_pin, permit_latch, ground_ok, low_req, hs_on, ls_on, ls_en, safe_cur;
   logic [31:0] q[$];
   logic [2:0] ch;
   diag_type m;
   int n_fail, cmp_count;
   squib_diag_spi_response #(.SHUTOFF_CYCLES(SHUT), .TIMEOUT_CYCLES(TMO),
      .SETTLE_CYCLES(SETTLE)) u_dut (
      .SYS_CLK(sys_clk), .NRST(nrst), .FRAME_DONE(frame_done), .CMD_WORD(cmd_word),
      .CMD_BITS(cmd_bits), .CS_FALL(cs_fall), .GROUND_LOST(ground_lost), .REF_FAULT(ref_fault),
      .DEPLOYING(deploying), .ARMED(armed), .BIAS_ON(bias_on), .LEAK_SEEN(leak_seen),
      .BATTERY_SHORT_CMP(bat_cmp), .GROUND_SHORT_CMP(gnd_cmp), .HIGH_RES_CMP(hr_cmp),
      .SAFE_CMP(safe_cmp), .RESERVE_CMP(res_cmp), .FIRE_PERMIT_PIN(permit_pin),
      .FIRE_PERMIT_LATCH(permit_latch), .GROUND_OK(ground_ok), .LOW_FIRE_REQ(low_req),
      .CURRENT_LIMIT_BITS(cl_bits), .RSP_WORD(rsp_word), .HS_MOS_ON(hs_on), .LS_MOS_ON(ls_on),
      .LS_FIRE_EN(ls_en), .SAFING_TEST_CURRENT(safe_cur), .SOFT_RESET(soft_reset));
   squib_host_model u_host (.clk(sys_clk), .frame_done(frame_done), .cmd_word(cmd_word),
      .cmd_bits(cmd_bits), .cs_fall(cs_fall));
   always #2.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) if (soft_reset) sr_seen <= 1'b1;
   function automatic logic [15:0] cmd(input logic [1:0] g, input logic [2:0] md,
      input logic [7:0] b);
      return {g, 3'b000, md, b};
   endfunction : cmd
   // Status answer: mode, then done, high-res, code, fault, timeout, battery, ground
   function automatic logic [15:0] st(input logic [2:0] md, input logic [7:0] f);
      return dw({2'b00, md, f});
   endfunction : st
   // Diagnostic answer with odd parity in D13
   function automatic logic [15:0] dw(input logic [12:0] v);
      logic [15:0] r;
      r = {3'b100, v};
      r[13] = ~^r;
      return r;
   endfunction : dw
   task automatic cmp_word(input logic [15:0] e, input logic [15:0] k, input logic [15:0] g);
      cmp_count++;
      if ((g & k) !== (e & k))
      begin
         n_fail++;
         $display("wrong value at %0t: expected %h got %h", $time, e & k, g & k);
      end
   endtask : cmp_word
   task automatic cmp_bit(input logic e, input logic g);
      cmp_word({15'h0000, e}, 16'h0001, {15'h0000, g});
   endtask : cmp_bit
   // Notes the answer due in this frame, then sends the next command
   task automatic xf(input logic [15:0] w, input logic [4:0] n, input logic gp,
      input logic [15:0] k, input logic [15:0] e);
      q.push_back({k, e});
      u_host.xfer(w, n, gp);
   endtask : xf
   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : wrap_up
   // The answer settles a cycle after the select fall
   always @(posedge sys_clk)
      if (cs_fall)
      begin
         logic [31:0] e;
         repeat (2) @(negedge sys_clk);
         e = q.pop_front();
         cmp_word(e[15:0], e[31:16], rsp_word);
      end
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      n_fail++;
      wrap_up();
   end
   initial
   begin
      {sys_clk, nrst, ground_lost, ref_fault, deploying, armed, leak_seen, bat_cmp} = '0;
      {gnd_cmp, hr_cmp, sr_seen, safe_cmp, res_cmp, permit_pin, permit_latch} = '0;
      {n_fail, cmp_count} = '0;
      low_req = 8'hFF;
      ground_ok = 8'hFF;
      bias_on = 1'b1; // Bias source on before any driver
      void'($urandom(32'h236b_8cf5));
      ch = 3'($urandom);
      cl_bits = $urandom_range(1) ? 2'b11 : 2'b00;
      repeat (3) @(negedge sys_clk);
      nrst = 1'b1;
      ground_ok = ~(8'h01 << ch);
      xf(cmd(GRP_DIAG, DG_HS, 8'(ch)), 16, 1, 16'hFFFF, 16'h0000);
      @(negedge sys_clk);
      cmp_bit(1'b1, hs_on[ch]);
      cmp_word({8'h00, ground_ok}, 16'h00FF, {8'h00, ls_en});
      bat_cmp = 1'b1;
      repeat (SHUT + 2) @(negedge sys_clk);
      cmp_bit(1'b0, hs_on[ch]);
      xf(MON, 16, 1, 16'hFFFF, dw({2'b00, DG_HS, 6'b100000, 2'b10}));
      bat_cmp = 1'b0;
      // Lost ground on this channel: with no ground short the low test times out
      xf(cmd(GRP_DIAG, DG_LS, 8'(ch)), 16, 1, 16'hFFFF, st(DG_HS, 8'h82));
      repeat (5) @(negedge sys_clk);
      cmp_bit(1'b1, ls_on[ch]);
      xf(MON, 16, 1, 16'hFFFF, st(DG_LS, 8'h04));
      repeat (TMO) @(negedge sys_clk);
      cmp_bit(1'b0, ls_on[ch]);
      // With its ground still lost, the low side sees its ground short and passes
      xf(cmd(GRP_DIAG, DG_LS, 8'(ch)), 16, 1, 16'hFFFF, st(DG_LS, 8'h80));
      @(negedge sys_clk);
      cmp_bit(1'b1, ls_on[ch]);
      gnd_cmp = 1'b1;
      repeat (SHUT) @(negedge sys_clk);
      cmp_bit(1'b0, ls_on[ch]);
      xf(MON, 16, 1, 16'hFFFF, st(DG_LS, 8'h81));
      gnd_cmp = 1'b0;
      for (int k = 0; k < 3; k++)
      begin
         permit_latch[ch] = k == 0;
         permit_pin[ch] = k == 1;
         bias_on = k != 2;
         ew = k == 0 ? st(DG_LS, 8'h81) : st(DG_HS, 8'h88);
         xf(cmd(GRP_DIAG, DG_HS, 8'(ch)), 16, 1, 16'hFFFF, ew);
         @(negedge sys_clk);
         cmp_bit(1'b0, hs_on[ch]);
         xf(MON, 16, 1, 16'hFFFF, st(DG_HS, 8'h88));
      end
      {permit_pin, permit_latch, bias_on} = {16'h0000, 1'b1};
      for (int k = 0; k < 9; k++)
      begin
         m = k < 3 ? DG_VRES : k < 6 ? DG_SAFE : DG_HIRES;
         c = k % 3 == 2 ? 2'b11 : 2'(k % 3);
         {safe_cmp, res_cmp, hr_cmp} = {c, c, c[0]};
         xf(cmd(GRP_DIAG, m, 8'(ch)), 16, 1, 16'h0000, 16'h0000);
         @(negedge sys_clk);
         cmp_bit(m == DG_SAFE, safe_cur[ch]);
         repeat (SETTLE + 2) @(negedge sys_clk);
         xf(MON, 16, 1, 16'hFF7F, dw({2'b00, m, 1'b0, (m == DG_HIRES) & c[0],
            m == DG_HIRES ? 2'b00 : c, 4'h0}));
      end
      xf(MON, 5'd15, 1, 16'h0000, 16'h0000);
      deploying = 1'b1;
      xf(MON, 16, 0, 16'hFFFF, 16'hD003);
      xf(cmd(GRP_DIAG, DG_LEAK, 8'(ch)), 16, 1, 16'hFFFF, 16'hD000);
      deploying = 1'b0;
      xf(cmd(GRP_DEP, DG_OFF, 8'h00), 16, 1, 16'hFFFF, 16'hD009);
      xf(cmd(GRP_CFG, DG_OFF, 8'hAA), 16, 1, 16'hFFFF, 16'hD005);
      xf(cmd(GRP_CFG, DG_OFF, 8'h55), 16, 1, 16'hFFFF, {6'h06, cl_bits, 8'h02});
      xf(MON, 16, 1, 16'hFFFF, 16'h2003);
      cmp_bit(1'b1, sr_seen);
      repeat (4) @(negedge sys_clk);
      wrap_up();
   end
endmodule : squib_diag_spi_response_tb_top
